// ===== pkg/eeprom_host_pkg.sv
// Constants and types for the two-wire serial memory host controller.
// Assumes one 100 MHz clock and a synchronous active-high reset.
// Bus and memory rules this block works to
// R1 - SDA changes only while SCL is low, except start and stop.
// R2 - Zero pulls SDA low; one releases it; nobody drives high.
// R3 - Start is SDA falling while SCL high; memory ignores bus before it.
// R4 - Stop is SDA rising while SCL high; it ends the session.
// R5 - Slave address is 1010, three select bits, then direction bit.
// R6 - Without select inputs the select bits must be all zero.
// R7 - Address bit zero: one reads, zero writes.
// R8 - Ninth clock: transmitter releases SDA, receiver pulls low to acknowledge.
// R9 - Byte write: start, address, two address bytes, data, stop.
// R10 - Stop after write starts programming; memory then acknowledges nothing.
// R11 - Memory buffers up to 32 bytes of one page.
// R12 - Page offset wraps within the page; later bytes overwrite earlier.
// R13 - All buffered bytes commit in one programming cycle after stop.
// R14 - Master repeats its request on no acknowledge until acknowledged; the controller gives up after POLL_TRIES retries.
// R15 - Write-protect high blocks all writes.
// R16 - Write-protect sampled before first data byte; if high, data refused.
// R17 - Delivered memory reads all-ones in every byte.
// R18 - Read without new address returns byte at current address.
// R19 - Chosen read: write address phase, then new start with read address.
// R20 - Master ends a read with no acknowledge then stop.
// R21 - Acknowledged read byte is followed by the next, wrapping the array.
// R22 - Memory captures on SCL rise, changes SDA on SCL fall.
// R23 - Array is 8192 bytes, 13-bit address, 32-byte pages.
// R24 - Rejected or data-less write starts no programming cycle.
package eeprom_host_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SCL_HZ = 100_000;
  localparam int unsigned QTR_CYCLES = CLK_HZ / (SCL_HZ * 4);
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned PAGE_BYTES = 32;
  localparam int unsigned POLL_MAX = 255;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] PH_LAST = 2'h3;
  localparam logic [7:0] POLL_LIMIT = 8'hFF;
  localparam logic [5:0] PAGE_LIMIT = 6'h20;
  typedef enum logic [1:0] {OP_WRITE, OP_READ_CUR, OP_READ_AT} op_t;
endpackage

// ===== pkg/data_buf_if.sv
// Write/read port bundle between the controller and its data buffer.
// Assumes the buffer shares the controller clock.
`timescale 1ns/1ps
`default_nettype none
interface data_buf_if;
  logic we;
  logic [4:0] waddr;
  logic [7:0] wdata;
  logic [4:0] raddr;
  logic [7:0] rdata;
  modport ctrl(output we, output waddr, output wdata, output raddr, input rdata);
  modport mem(input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// ===== rtl/byte_buf.sv
// Small byte memory holding one page of write or read data.
// Assumes one clock; read data registered, one cycle after address.
`timescale 1ns/1ps
`default_nettype none
module byte_buf #(
  parameter int unsigned DEPTH = 32
) (
  // Clock
  input wire logic clk,
  // Access port
  data_buf_if.mem bus
);
  logic [7:0] mem_ff [DEPTH];
  logic [7:0] rdata_ff;
  always_ff @(posedge clk) begin
    if (bus.we) begin
      mem_ff[bus.waddr] <= bus.wdata;
    end
  end
  always_ff @(posedge clk) begin
    rdata_ff <= mem_ff[bus.raddr];
  end
  assign bus.rdata = rdata_ff;
endmodule
`default_nettype wire

// ===== rtl/eeprom_host.sv
// Host controller that drives a two-wire serial memory as bus master.
// Assumes pull-ups on SCL and SDA; software loads the buffer, then starts.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module eeprom_host
  import eeprom_host_pkg::*;
#(
  parameter int unsigned POLL_TRIES = POLL_MAX,
  parameter int unsigned QTR_TICKS = QTR_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Software register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Serial bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n
);
  import eeprom_host_pkg::*;

  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_DATA = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hC;

  typedef enum {
    ST_IDLE, ST_START, ST_SHIFT, ST_ACK, ST_STOP, ST_RSTART
  } state_t;

  typedef enum {
    PH_DEV, PH_AHI, PH_ALO, PH_DATA, PH_RDEV, PH_RDATA
  } phase_t;

  data_buf_if buf_if();
  byte_buf #(.DEPTH(PAGE_BYTES)) u_buf (.clk(clk), .bus(buf_if));

  state_t state_ff;
  phase_t phase_ff;
  op_t op_ff;
  logic [2:0] sel_ff;
  logic [ADDR_W-1:0] maddr_ff;
  logic [5:0] count_ff;
  logic [5:0] idx_ff;
  logic [7:0] sh_ff;
  logic [2:0] bit_ff;
  logic [1:0] q_ff;
  logic [15:0] div_ff;
  logic tick;
  logic busy_ff, done_ff, nack_ff;
  logic [7:0] tries_ff;
  logic sda_s1_ff, sda_s2_ff, scl_s1_ff, scl_s2_ff;
  logic sda_drv_ff, scl_drv_ff;
  logic [5:0] wptr_ff;
  logic [7:0] rd_byte_ff;
  logic go_pulse;
  logic [7:0] nxt_tx;

  function automatic logic [7:0] dev_byte(input logic [2:0] sel, input logic dir);
    dev_byte = {DEV_TYPE, sel, dir};
  endfunction

  // Synchronise the pins; only the second stage is read
  always_ff @(posedge clk) begin
    sda_s1_ff <= sda_in;
    sda_s2_ff <= sda_s1_ff;
    scl_s1_ff <= scl_in;
    scl_s2_ff <= scl_s1_ff;
  end

  // Quarter-period enable; stretches while a far end holds SCL low
  always_ff @(posedge clk) begin
    if (rst || tick) begin
      div_ff <= '0;
    end else if (!(scl_drv_ff && !scl_s2_ff && q_ff == 2'h2)) begin
      div_ff <= div_ff + 16'h0001;
    end
  end
  assign tick = (div_ff == 16'(QTR_TICKS - 1));

  assign go_pulse = reg_wr && reg_addr == REG_CTRL && reg_wdata[0] && !busy_ff;

  // Bytes are staged for sending by position in the transfer
  always_comb begin
    case (phase_ff)
      PH_DEV: nxt_tx = dev_byte(sel_ff, (op_ff == OP_READ_CUR) ? DIR_READ : DIR_WRITE); // see R7
      PH_AHI: nxt_tx = 8'({3'h0, maddr_ff[ADDR_W-1:8]}); // see R23
      PH_ALO: nxt_tx = maddr_ff[7:0];
      PH_RDEV: nxt_tx = dev_byte(sel_ff, DIR_READ); // see R19
      default: nxt_tx = buf_if.rdata;
    endcase
  end

  // Bus sequencer: four quarters per bit, SCL high in quarters 2 and 3
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      phase_ff <= PH_DEV;
      q_ff <= '0;
      bit_ff <= '0;
      sh_ff <= '0;
      idx_ff <= '0;
      scl_drv_ff <= 1'b1;
      sda_drv_ff <= 1'b1;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      nack_ff <= 1'b0;
      tries_ff <= '0;
      rd_byte_ff <= '0;
    end else if (go_pulse) begin
      state_ff <= ST_START;
      phase_ff <= PH_DEV;
      q_ff <= '0;
      idx_ff <= '0;
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
      nack_ff <= 1'b0;
      tries_ff <= '0;
    end else if (tick) begin
      q_ff <= q_ff + 2'h1;
      case (state_ff)
        ST_IDLE: begin
          scl_drv_ff <= 1'b1;
          sda_drv_ff <= 1'b1;
        end
        ST_START, ST_RSTART: begin
          // SDA falls while SCL high; see R3
          case (q_ff)
            2'h0: begin sda_drv_ff <= 1'b1; scl_drv_ff <= 1'b1; end
            2'h1: sda_drv_ff <= 1'b0;
            2'h2: scl_drv_ff <= 1'b0;
            default: begin
              state_ff <= ST_SHIFT;
              sh_ff <= nxt_tx;
              bit_ff <= '0;
            end
          endcase
        end
        ST_SHIFT: begin
          case (q_ff)
            2'h0: begin
              // Data moves only with SCL low; see R1 R2
              sda_drv_ff <= (phase_ff == PH_RDATA) ? 1'b1 : sh_ff[7];
            end
            2'h1: scl_drv_ff <= 1'b1;
            2'h2: sh_ff <= {sh_ff[6:0], sda_s2_ff};
            default: begin
              scl_drv_ff <= 1'b0;
              bit_ff <= bit_ff + 3'h1;
              if (bit_ff == BIT_LAST) begin
                state_ff <= ST_ACK;
              end
            end
          endcase
        end
        ST_ACK: begin
          case (q_ff)
            2'h0: begin
              // Release for slave ack, or ack read bytes ourselves; see R8 R20 R21
              if (phase_ff == PH_RDATA) begin
                sda_drv_ff <= (idx_ff + 6'h01 == count_ff);
              end else begin
                sda_drv_ff <= 1'b1;
              end
            end
            2'h1: scl_drv_ff <= 1'b1;
            2'h2: begin
              if (phase_ff == PH_RDATA) begin
                rd_byte_ff <= sh_ff;
              end else if (sda_s2_ff) begin
                nack_ff <= 1'b1; // see R10 R16
              end
            end
            default: begin
              scl_drv_ff <= 1'b0;
              state_ff <= ST_SHIFT;
              bit_ff <= '0;
              if (nack_ff) begin
                state_ff <= ST_STOP;
              end else begin
                case (phase_ff)
                  PH_DEV: phase_ff <= (op_ff == OP_READ_CUR) ? PH_RDATA : PH_AHI; // see R18
                  PH_AHI: phase_ff <= PH_ALO;
                  PH_ALO: begin
                    if (op_ff == OP_READ_AT) begin
                      phase_ff <= PH_RDEV;
                      state_ff <= ST_RSTART;
                    end else begin
                      phase_ff <= PH_DATA; // see R9
                    end
                  end
                  PH_RDEV: phase_ff <= PH_RDATA;
                  PH_DATA: idx_ff <= idx_ff + 6'h01; // see R11
                  default: idx_ff <= idx_ff + 6'h01;
                endcase
                if ((phase_ff == PH_DATA || phase_ff == PH_RDATA) &&
                    idx_ff + 6'h01 == count_ff) begin
                  state_ff <= ST_STOP;
                end
              end
            end
          endcase
          if (q_ff == PH_LAST && !nack_ff) begin
            if (phase_ff == PH_ALO && op_ff == OP_WRITE) begin
              sh_ff <= buf_if.rdata;
            end else if (phase_ff == PH_DEV && op_ff != OP_READ_CUR) begin
              // Address high byte follows the device byte
              sh_ff <= 8'({3'h0, maddr_ff[ADDR_W-1:8]}); // see R23
            end else if (phase_ff == PH_AHI) begin
              sh_ff <= maddr_ff[7:0];
            end else if (phase_ff == PH_DATA) begin
              sh_ff <= buf_if.rdata;
            end
          end
        end
        default: begin
          // SDA rises while SCL high; see R4
          case (q_ff)
            2'h0: sda_drv_ff <= 1'b0;
            2'h1: scl_drv_ff <= 1'b1;
            2'h2: sda_drv_ff <= 1'b1;
            default: begin
              // Retry address on no-ack while memory programs; see R14
              if (nack_ff && phase_ff == PH_DEV && tries_ff != 8'(POLL_TRIES)) begin
                tries_ff <= tries_ff + 8'h01;
                nack_ff <= 1'b0;
                state_ff <= ST_START;
              end else begin
                state_ff <= ST_IDLE;
                busy_ff <= 1'b0;
                done_ff <= 1'b1;
              end
            end
          endcase
        end
      endcase
    end
  end

  // Buffer read index: while a data byte goes out, the next one is fetched
  assign buf_if.raddr = 5'(idx_ff + ((phase_ff == PH_DATA) ? 6'h01 : 6'h00));

  // Software writes fill the buffer; read bytes land there too
  always_ff @(posedge clk) begin
    if (rst || go_pulse) begin
      wptr_ff <= '0;
    end else if (reg_wr && reg_addr == REG_DATA) begin
      wptr_ff <= wptr_ff + 6'h01;
    end
  end
  assign buf_if.we = (reg_wr && reg_addr == REG_DATA) ||
    (tick && state_ff == ST_ACK && q_ff == PH_LAST && phase_ff == PH_RDATA);
  assign buf_if.waddr = (reg_wr && reg_addr == REG_DATA) ? wptr_ff[4:0] : idx_ff[4:0];
  assign buf_if.wdata = (reg_wr && reg_addr == REG_DATA) ? reg_wdata[7:0] : rd_byte_ff;

  // Command registers
  always_ff @(posedge clk) begin
    if (rst) begin
      op_ff <= OP_WRITE;
      sel_ff <= '0; // see R6
      count_ff <= 6'h01;
      maddr_ff <= '0;
    end else if (reg_wr && !busy_ff) begin
      if (reg_addr == REG_CTRL) begin
        op_ff <= op_t'(reg_wdata[2:1]);
        sel_ff <= reg_wdata[5:3]; // see R5
        count_ff <= (reg_wdata[13:8] == 6'h00 || reg_wdata[13:8] > PAGE_LIMIT) ?
          6'h01 : reg_wdata[13:8]; // see R12
      end else if (reg_addr == REG_ADDR) begin
        maddr_ff <= reg_wdata[ADDR_W-1:0];
      end
    end
  end

  // Registered read port; data reads return the last received byte, rd_byte_ff
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (reg_addr == REG_STAT) begin
        reg_rdata <= {21'h0, tries_ff, nack_ff, done_ff, busy_ff};
      end else if (reg_addr == REG_ADDR) begin
        reg_rdata <= 32'(maddr_ff);
      end else if (reg_addr == REG_CTRL) begin
        reg_rdata <= {18'h0, count_ff, 2'h0, sel_ff, op_ff, 1'b0};
      end else if (reg_addr == REG_DATA) begin
        reg_rdata <= {24'h0, rd_byte_ff};
      end else begin
        reg_rdata <= '0;
      end
    end else begin
      reg_rdata <= '0;
    end
  end

  // Open drain: drive low only, enable low while driving; see R2
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = scl_drv_ff;
  assign sda_oe_n = sda_drv_ff;

  a_sda_stable_high: assert property (@(posedge clk) disable iff (rst) // see R1
    (state_ff == ST_SHIFT && scl_drv_ff && $past(scl_drv_ff)) |-> $stable(sda_drv_ff))
    else $error("SDA moved while SCL high");
  a_start_shape: assert property (@(posedge clk) disable iff (rst) // see R3
    ($fell(sda_drv_ff) && scl_drv_ff) |-> (state_ff == ST_START || state_ff == ST_RSTART))
    else $error("SDA fell with SCL high outside start");
  a_stop_shape: assert property (@(posedge clk) disable iff (rst) // see R4
    ($rose(sda_drv_ff) && scl_drv_ff && state_ff != ST_IDLE) |-> state_ff == ST_STOP
      || (state_ff == ST_START && q_ff == 2'h1))
    else $error("SDA rose with SCL high outside stop");
  a_no_drive_high: assert property (@(posedge clk) disable iff (rst) // see R2
    scl_out == 1'b0 && sda_out == 1'b0)
    else $error("Pin driven high");
  a_ack_release: assert property (@(posedge clk) disable iff (rst) // see R8
    (state_ff == ST_ACK && q_ff == 2'h2 && phase_ff != PH_RDATA) |-> sda_drv_ff)
    else $error("SDA not released for ack");
  a_dev_type: assert property (@(posedge clk) disable iff (rst) // see R5
    (phase_ff == PH_DEV) |-> nxt_tx[7:4] == DEV_TYPE)
    else $error("Wrong type field");
  a_last_nack: assert property (@(posedge clk) disable iff (rst) // see R20
    (state_ff == ST_ACK && q_ff == 2'h2 && phase_ff == PH_RDATA &&
     idx_ff + 6'h01 == count_ff) |-> sda_drv_ff)
    else $error("Final read byte acknowledged");
  a_nack_stops: assert property (@(posedge clk) disable iff (rst) // see R14
    (tick && state_ff == ST_ACK && q_ff == PH_LAST && nack_ff) |=> state_ff == ST_STOP)
    else $error("No stop after no-ack");
  a_write_order: assert property (@(posedge clk) disable iff (rst) // see R9
    (tick && state_ff == ST_ACK && q_ff == PH_LAST && phase_ff == PH_ALO &&
     op_ff == OP_WRITE && !nack_ff) |=> (phase_ff == PH_DATA && state_ff == ST_SHIFT))
    else $error("Data byte does not follow address");
  a_retry_bound: assert property (@(posedge clk) disable iff (rst) // see R14
    tries_ff <= 8'(POLL_TRIES))
    else $error("Too many address retries");
endmodule
`default_nettype wire

// ===== bench/eeprom_model.sv
// Behavioural two-wire serial memory answering the host controller.
// Assumes pulled-up bus lines resolved by the bench; pull high means SDA low.
`timescale 1ns/1ps
`default_nettype none
module eeprom_model (
  // Bus lines
  input wire logic scl,
  input wire logic sda,
  // Straps
  input wire logic [2:0] sel,
  input wire logic wp,
  // Open-drain drive
  output logic pull
);
  // Shortened so that the first poll is refused and a retry follows
  localparam time internal_program_time = 30us;
  logic [7:0] mem [8192];
  logic [7:0] pg [32];
  logic [31:0] pgv;
  logic [7:0] sh, ob, ahi;
  logic [12:0] ptr;
  logic [3:0] cnt;
  logic [1:0] ph;
  logic act, rd, snd, busy, wpl, rej, skip;
  int nb;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    pull = 0; act = 0; busy = 0; rd = 0; snd = 0; rej = 0; nb = 0; skip = 0;
  end
  always @(negedge sda) if (scl) begin
    act = 1; skip = 1; cnt = 0; ph = 0; rd = 0; snd = 0; pull = 0;
  end
  always @(posedge sda) if (scl) begin
    if (act && !rd && !rej && ph == 2'h3 && nb > 0) begin
      for (int i = 0; i < 32; i++) if (pgv[i]) mem[{ptr[12:5], i[4:0]}] = pg[i];
      busy = 1;
      busy <= #internal_program_time 1'b0;
    end
    act = 0; pull = 0;
  end
  always @(posedge scl) if (act) begin
    if (cnt < 8) sh = {sh[6:0], sda};
    else if (rd) snd = !sda;
  end
  always @(negedge scl) if (act) begin
    // The fall that closes a start is not a bit boundary
    if (skip) skip = 0;
    else if (cnt < 7) begin
      cnt = cnt + 1;
      if (snd) pull = !ob[7 - cnt];
    end else if (cnt == 7) begin
      cnt = 8;
      if (snd) pull = 0;
      else case (ph)
        2'h0: if (sh[7:1] == {4'hA, sel} && !busy) begin
          rd = sh[0]; snd = sh[0]; ph = 1; pull = 1;
        end else begin
          act = 0; pull = 0;
        end
        2'h1: begin ahi = sh; ph = 2; pull = 1; end
        2'h2: begin
          ptr = {ahi[4:0], sh}; ph = 3; nb = 0; pgv = 0; rej = 0; pull = 1;
        end
        default: if (wpl) begin
          rej = 1; act = 0; pull = 0;
        end else begin
          pg[ptr[4:0]] = sh; pgv[ptr[4:0]] = 1; ptr[4:0] = ptr[4:0] + 1; nb++; pull = 1;
        end
      endcase
    end else begin
      cnt = 0;
      if (ph == 2'h3 && nb == 0) wpl = wp;
      if (snd) begin
        ob = mem[ptr]; ptr = ptr + 1; pull = !ob[7];
      end else pull = 0;
    end
  end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the serial memory host controller.
// Assumes the memory model beside it; register reads checked from a queue.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import eeprom_host_pkg::*;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, want = 0, want_d = 0;
  logic [3:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic scl_oe_n, sda_oe_n, scl_out, sda_out, pull, wp = 0;
  logic [2:0] sel;
  logic [7:0] d0, d1;
  logic [31:0] exp_q[$], msk_q[$];
  int n_errors = 0, cmp_count = 0, cyc = 0, seed = 32'hd607;
  wire scl_w = scl_oe_n;
  wire sda_w = sda_oe_n & ~pull;
  always #5 clk = ~clk;
  // Faster bus than the default keeps the run short
  eeprom_host #(.POLL_TRIES(4), .QTR_TICKS(50)) eeprom_host_inst (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  eeprom_model eeprom_model_inst (.scl(scl_w), .sda(sda_w), .sel(sel), .wp(wp), .pull(pull));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task close_out;
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task reg_read(input logic [3:0] a, input logic chk, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    reg_addr <= a; reg_rd <= 1; want <= chk;
    if (chk) begin
      exp_q.push_back(e & m);
      msk_q.push_back(m);
    end
    @(posedge clk);
    reg_rd <= 0; want <= 0;
  endtask
  // Busy is not tested right after go: status may lag the strobe
  task wait_done;
    int k;
    k = 0;
    repeat (4) @(posedge clk);
    reg_read(4'hC, 0, 0, 0);
    #1;
    while (reg_rdata[0] !== 1'b0 && k < 12000) begin
      @(posedge clk);
      reg_read(4'hC, 0, 0, 0);
      #1;
      k++;
    end
    if (k == 12000) n_errors++;
  endtask
  function logic [31:0] ctrl(input op_t op, input logic [5:0] n);
    return {18'h0, n, 2'b00, sel, op, 1'b1};
  endfunction
  always @(posedge clk) begin
    if (want_d) check(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
    want_d <= want;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    sel = 3'($random(seed));
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    repeat (20) @(posedge clk);
    rst <= 0;
    reg_read(4'hC, 1, 32'h0, 32'h7FF);
    reg_write(4'h6, $random(seed));
    reg_write(4'h8, {24'h0, d0});
    reg_write(4'h8, {24'h0, d1});
    // Two bytes from the last page offset: the second wraps to the page start
    reg_write(4'h4, 32'h1F);
    reg_write(4'h0, ctrl(OP_WRITE, 6'h02));
    wait_done();
    reg_read(4'hC, 1, 32'h2, 32'h7);
    check({24'h0, eeprom_model_inst.mem[13'h001F]}, {24'h0, d0});
    check({24'h0, eeprom_model_inst.mem[13'h0000]}, {24'h0, d1});
    check({24'h0, eeprom_model_inst.mem[13'h0020]}, 32'hFF);
    // Issued at once, so the memory is still programming and refuses
    // Two bytes from the last location: the second wraps to the first
    reg_write(4'h4, 32'h1FFF);
    reg_write(4'h0, ctrl(OP_READ_AT, 6'h02));
    wait_done();
    reg_read(4'hC, 1, 32'h2, 32'h7);
    #1 check({31'h0, reg_rdata[10:3] != 8'h00}, 32'h1);
    reg_read(4'h8, 1, {24'h0, d1}, 32'hFF);
    // Count field zero means one byte
    reg_write(4'h0, ctrl(OP_READ_CUR, 6'h00));
    wait_done();
    reg_read(4'hC, 1, 32'h2, 32'h7);
    reg_read(4'h8, 1, 32'hFF, 32'hFF);
    // Protected write: data byte refused, nothing programmed
    wp <= 1;
    reg_write(4'h8, {24'h0, d0});
    reg_write(4'h4, 32'h20);
    reg_write(4'h0, ctrl(OP_WRITE, 6'h01));
    wait_done();
    reg_read(4'hC, 1, 32'h6, 32'h7FF);
    check({24'h0, eeprom_model_inst.mem[13'h0020]}, 32'hFF);
    // No programming cycle, so the next request is taken at once
    reg_write(4'h0, ctrl(OP_READ_CUR, 6'h01));
    wait_done();
    reg_read(4'hC, 1, 32'h2, 32'h7FF);
    reg_read(4'h8, 1, 32'hFF, 32'hFF);
    repeat (4) @(posedge clk);
    check({28'h0, scl_out, sda_out, scl_oe_n, sda_oe_n}, 32'h3);
    close_out();
  end
endmodule
`default_nettype wire
